/* File: verilog/irq_latch_map.svh */
`ifndef IRQ_LATCH_MAP_SVH
`define IRQ_LATCH_MAP_SVH

// ************************************************************
// Register byte addresses
// ************************************************************
`define REQ_BANK0_ADDR   12'hfc0
`define EN_HIGH0_ADDR    12'hfc1
`define EN_LOW0_ADDR     12'hfc2
`define REQ_BANK1_ADDR   12'hfc3
`define EN_HIGH1_ADDR    12'hfc4
`define EN_LOW1_ADDR     12'hfc5
`define REQ_BANK2_ADDR   12'hfc6
`define EN_HIGH2_ADDR    12'hfc7
`define EN_LOW2_ADDR     12'hfc8
`define GATE_CTRL_ADDR   12'hfe0
`define EVT_STATUS_ADDR  12'hfe1
`define EVT_CLEAR_ADDR   12'hfe2
`define EVT_ENABLE_ADDR  12'hfe3

// ************************************************************
// Implemented bits and reset values
// ************************************************************
`define BANK0_MASK       8'h79
`define BANK1_MASK       8'hff
`define BANK2_MASK       8'h0f
`define BYTE_RESET       8'h00
`define BYTE_ZERO        8'h00
`define EVT_MASK         8'h07

// ************************************************************
// Field positions
// ************************************************************
`define GATE_BIT         0
`define EVT_OVERRUN_BIT  0
`define EVT_ACK_BIT      1
`define EVT_STRAY_BIT    2

// ************************************************************
// Acknowledge bank codes
// ************************************************************
`define ACK_BANK0        2'h0
`define ACK_BANK1        2'h1
`define ACK_BANK2        2'h2

`endif

/* File: verilog/irq_latch_pkg.sv */
package irq_latch_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [11:0] addr_t;

  typedef struct packed {
    logic  wr;
    logic  rd;
    addr_t addr;
    byte_t wdata;
  } reg_req_t;

  typedef struct packed {
    logic       timer_one_request;
    logic       timer_zero_request;
    logic       serial_receive_request;
    logic       serial_transmit_request;
    logic       converter_request;
    logic       porta_pin7_or_voltage_request;
    logic       porta_pin6_or_comparator_request;
    logic [5:0] porta_pin_request;
    logic [3:0] portc_pin_request;
  } source_pulse_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] bank;
    logic [2:0] bit_sel;
  } core_ack_t;

  typedef struct packed {
    logic enable_instr;
    logic iret_instr;
    logic disable_instr;
    logic trap;
  } gate_ctrl_t;

  typedef struct packed {
    byte_t bank2;
    byte_t bank1;
    byte_t bank0;
  } req_vec_t;

endpackage

/* File: verilog/request_bank.sv */
`include "irq_latch_map.svh"

module request_bank #(
  parameter irq_latch_pkg::byte_t IMPL_MASK = `BANK1_MASK
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 ce_i,
  input  wire irq_latch_pkg::byte_t hw_set_i,
  input  wire logic                 sw_wr_i,
  input  wire irq_latch_pkg::byte_t sw_data_i,
  input  wire irq_latch_pkg::byte_t ack_clr_i,
  output      irq_latch_pkg::byte_t bank_q_o,
  output      logic                 overrun_o
);
  import irq_latch_pkg::*;

  byte_t bank_q;
  byte_t bank_d;
  byte_t held;
  byte_t hw_m;

  // Hardware pulse is ORed last so it survives a clear in the same cycle
  assign hw_m   = hw_set_i & IMPL_MASK;
  assign held   = sw_wr_i ? sw_data_i : bank_q;
  assign bank_d = ((held & ~ack_clr_i) | hw_m) & IMPL_MASK;
  assign bank_q_o  = bank_q;
  assign overrun_o = |(hw_m & bank_q);

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      bank_q <= `BYTE_RESET;
    else if (ce_i)
      bank_q <= bank_d;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_pulse_sets_bit: assert property (ce_i && hw_m != `BYTE_ZERO |=> (bank_q & $past(hw_m)) == $past(hw_m))
    else $error("request pulse did not set its bit");
  a_ack_clears_bit: assert property (ce_i && (ack_clr_i & ~hw_m) != `BYTE_ZERO
                                     |=> (bank_q & $past(ack_clr_i & ~hw_m)) == `BYTE_ZERO)
    else $error("acknowledge did not clear its bit");
  a_write_loads_bank: assert property (ce_i && sw_wr_i
                                       |=> bank_q == ($past((sw_data_i & ~ack_clr_i) | hw_m) & IMPL_MASK))
    else $error("software write not applied to bank");
  a_idle_holds_bank: assert property (ce_i && !sw_wr_i && ack_clr_i == `BYTE_ZERO && hw_m == `BYTE_ZERO
                                      |=> $stable(bank_q))
    else $error("request bit changed without cause");
  a_reserved_stay_zero: assert property ((bank_q & ~IMPL_MASK) == `BYTE_ZERO)
    else $error("reserved request bit set");
  a_reset_clears_bank: assert property (disable iff (1'b0) !reset_n_i |=> bank_q == `BYTE_RESET)
    else $error("reset did not clear bank");
endmodule

/* File: verilog/master_gate.sv */
`include "irq_latch_map.svh"

module master_gate (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output      logic gate_o
);
  import irq_latch_pkg::*;

  logic gate_q;
  logic gate_d;

  // Clear wins: a disable or trap must never be undone by a racing enable
  assign gate_d = clr_i ? 1'b0 : (set_i ? 1'b1 : gate_q);
  assign gate_o = gate_q;

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      gate_q <= 1'b0;
    else if (ce_i)
      gate_q <= gate_d;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_gate_set_path: assert property (ce_i && set_i && !clr_i |=> gate_q)
    else $error("master gate not set");
  a_gate_clear_path: assert property (ce_i && clr_i |=> !gate_q)
    else $error("master gate not cleared");
endmodule

/* File: verilog/interrupt_request_latch.sv */
`include "irq_latch_map.svh"

module interrupt_request_latch (
  input  wire logic                         core_clk_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         ce_i,
  input  wire irq_latch_pkg::reg_req_t      reg_req_i,
  output      irq_latch_pkg::byte_t         reg_rdata_o,
  input  wire irq_latch_pkg::source_pulse_t pulses_i,
  input  wire irq_latch_pkg::gate_ctrl_t    gate_ctrl_i,
  input  wire irq_latch_pkg::core_ack_t     ack_i,
  output      logic                         master_gate_o,
  output      logic                         vectored_request_o,
  output      irq_latch_pkg::req_vec_t      request_bits_o,
  output      irq_latch_pkg::req_vec_t      enable_high_o,
  output      irq_latch_pkg::req_vec_t      enable_low_o,
  output      logic                         intr_o
);
  import irq_latch_pkg::*;

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic byte_t ack_onehot(input core_ack_t a, input logic [1:0] bank);
    byte_t v;
    v = `BYTE_ZERO;
    if (a.valid && a.bank == bank)
      v[a.bit_sel] = 1'b1;
    return v;
  endfunction

  // Nonzero pair means enabled at some level
  function automatic req_vec_t pair_enabled(input req_vec_t hi, input req_vec_t lo);
    return hi | lo;
  endfunction

  // ************************************************************
  // Address decode
  // ************************************************************
  wire logic wr = reg_req_i.wr;
  wire logic rd = reg_req_i.rd;
  wire addr_t adr = reg_req_i.addr;
  wire byte_t wdat = reg_req_i.wdata;

  wire logic wr_bank0 = wr && (adr == `REQ_BANK0_ADDR);
  wire logic wr_bank1 = wr && (adr == `REQ_BANK1_ADDR);
  wire logic wr_bank2 = wr && (adr == `REQ_BANK2_ADDR);
  wire logic wr_enh0  = wr && (adr == `EN_HIGH0_ADDR);
  wire logic wr_enl0  = wr && (adr == `EN_LOW0_ADDR);
  wire logic wr_enh1  = wr && (adr == `EN_HIGH1_ADDR);
  wire logic wr_enl1  = wr && (adr == `EN_LOW1_ADDR);
  wire logic wr_enh2  = wr && (adr == `EN_HIGH2_ADDR);
  wire logic wr_enl2  = wr && (adr == `EN_LOW2_ADDR);
  wire logic wr_gate  = wr && (adr == `GATE_CTRL_ADDR);
  wire logic wr_eclr  = wr && (adr == `EVT_CLEAR_ADDR);
  wire logic wr_eena  = wr && (adr == `EVT_ENABLE_ADDR);

  // ************************************************************
  // Source pulse routing
  // ************************************************************
  // Sources pulse for one cycle; a held level would simply re-set the bit
  wire byte_t set_bank0 = {1'b0,
                           pulses_i.timer_one_request,
                           pulses_i.timer_zero_request,
                           pulses_i.serial_receive_request,
                           pulses_i.serial_transmit_request,
                           2'b00,
                           pulses_i.converter_request};
  wire byte_t set_bank1 = {pulses_i.porta_pin7_or_voltage_request,
                           pulses_i.porta_pin6_or_comparator_request,
                           pulses_i.porta_pin_request};
  wire byte_t set_bank2 = {4'h0, pulses_i.portc_pin_request};

  wire byte_t clr_bank0 = ack_onehot(ack_i, `ACK_BANK0);
  wire byte_t clr_bank1 = ack_onehot(ack_i, `ACK_BANK1);
  wire byte_t clr_bank2 = ack_onehot(ack_i, `ACK_BANK2);

  // ************************************************************
  // Request banks
  // ************************************************************
  byte_t bank0_q;
  byte_t bank1_q;
  byte_t bank2_q;
  logic  ovr0;
  logic  ovr1;
  logic  ovr2;

  request_bank #(.IMPL_MASK(`BANK0_MASK)) u_bank0 (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .hw_set_i   (set_bank0),
    .sw_wr_i    (wr_bank0),
    .sw_data_i  (wdat),
    .ack_clr_i  (clr_bank0),
    .bank_q_o   (bank0_q),
    .overrun_o  (ovr0)
  );

  request_bank #(.IMPL_MASK(`BANK1_MASK)) u_bank1 (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .hw_set_i   (set_bank1),
    .sw_wr_i    (wr_bank1),
    .sw_data_i  (wdat),
    .ack_clr_i  (clr_bank1),
    .bank_q_o   (bank1_q),
    .overrun_o  (ovr1)
  );

  request_bank #(.IMPL_MASK(`BANK2_MASK)) u_bank2 (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .hw_set_i   (set_bank2),
    .sw_wr_i    (wr_bank2),
    .sw_data_i  (wdat),
    .ack_clr_i  (clr_bank2),
    .bank_q_o   (bank2_q),
    .overrun_o  (ovr2)
  );

  wire req_vec_t req_all = '{bank2: bank2_q, bank1: bank1_q, bank0: bank0_q};

  // ************************************************************
  // Enable pairs
  // ************************************************************
  req_vec_t en_high_q;
  req_vec_t en_low_q;

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      en_high_q <= '0;
      en_low_q  <= '0;
    end
    else if (ce_i)
    begin
      if (wr_enh0) en_high_q.bank0 <= wdat & `BANK0_MASK;
      if (wr_enl0) en_low_q.bank0  <= wdat & `BANK0_MASK;
      if (wr_enh1) en_high_q.bank1 <= wdat & `BANK1_MASK;
      if (wr_enl1) en_low_q.bank1  <= wdat & `BANK1_MASK;
      if (wr_enh2) en_high_q.bank2 <= wdat & `BANK2_MASK;
      if (wr_enl2) en_low_q.bank2  <= wdat & `BANK2_MASK;
    end
  end

  wire req_vec_t enabled_pending = req_all & pair_enabled(en_high_q, en_low_q);

  // ************************************************************
  // Master gate
  // ************************************************************
  // Watchdog and oscillator-fail traps arrive only as gate_ctrl_i.trap;
  // they never pass through the banks or enable pairs
  wire logic gate_set = gate_ctrl_i.enable_instr || gate_ctrl_i.iret_instr ||
                        (wr_gate && wdat[`GATE_BIT]);
  wire logic gate_clr = gate_ctrl_i.disable_instr || gate_ctrl_i.trap || ack_i.valid ||
                        (wr_gate && !wdat[`GATE_BIT]);
  logic gate;

  master_gate u_gate (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .ce_i       (ce_i),
    .set_i      (gate_set),
    .clr_i      (gate_clr),
    .gate_o     (gate)
  );

  // Gate shut: bits keep latching, only forwarding stops
  assign vectored_request_o = gate && (enabled_pending != '0);
  assign master_gate_o      = gate;
  assign request_bits_o     = req_all;
  assign enable_high_o      = en_high_q;
  assign enable_low_o       = en_low_q;

  // ************************************************************
  // Event status and interrupt line
  // ************************************************************
  wire logic stray_ack = ack_i.valid &&
    (((clr_bank0 & bank0_q) | (clr_bank1 & bank1_q) | (clr_bank2 & bank2_q)) == `BYTE_ZERO);
  wire byte_t evt_raw = {5'h00, stray_ack, ack_i.valid, (ovr0 || ovr1 || ovr2)};

  byte_t evt_status_q;
  byte_t evt_enable_q;
  // Set after clear so a same-cycle event survives the clear
  wire byte_t evt_clr = wr_eclr ? wdat : `BYTE_ZERO;
  wire byte_t evt_status_d = ((evt_status_q & ~evt_clr) | evt_raw) & `EVT_MASK;

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      evt_status_q <= `BYTE_RESET;
      evt_enable_q <= `BYTE_RESET;
    end
    else if (ce_i)
    begin
      evt_status_q <= evt_status_d;
      if (wr_eena)
        evt_enable_q <= wdat & `EVT_MASK;
    end
  end

  assign intr_o = (evt_status_q & evt_enable_q) != `BYTE_ZERO;

  // ************************************************************
  // Read path
  // ************************************************************
  // Reads have no side effects; polling is safe with the gate shut
  byte_t rd_mux;
  byte_t rdata_q;

  always_comb
  begin
    if (adr == `REQ_BANK0_ADDR)
      rd_mux = bank0_q;
    else if (adr == `REQ_BANK1_ADDR)
      rd_mux = bank1_q;
    else if (adr == `REQ_BANK2_ADDR)
      rd_mux = bank2_q;
    else if (adr == `EN_HIGH0_ADDR)
      rd_mux = en_high_q.bank0;
    else if (adr == `EN_LOW0_ADDR)
      rd_mux = en_low_q.bank0;
    else if (adr == `EN_HIGH1_ADDR)
      rd_mux = en_high_q.bank1;
    else if (adr == `EN_LOW1_ADDR)
      rd_mux = en_low_q.bank1;
    else if (adr == `EN_HIGH2_ADDR)
      rd_mux = en_high_q.bank2;
    else if (adr == `EN_LOW2_ADDR)
      rd_mux = en_low_q.bank2;
    else if (adr == `GATE_CTRL_ADDR)
      rd_mux = {7'h00, gate};
    else if (adr == `EVT_STATUS_ADDR)
      rd_mux = evt_status_q;
    else if (adr == `EVT_ENABLE_ADDR)
      rd_mux = evt_enable_q;
    else
      rd_mux = `BYTE_ZERO;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      rdata_q <= `BYTE_ZERO;
    else if (ce_i)
      rdata_q <= rd ? rd_mux : `BYTE_ZERO;
  end

  assign reg_rdata_o = rdata_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  a_forward_when_open: assert property (vectored_request_o == (gate && (enabled_pending != '0)))
    else $error("forwarding does not follow gate and pending");
  a_pending_open_gate: assert property (ce_i && gate && !gate_clr && pulses_i.timer_one_request &&
                                        (en_high_q.bank0[6] || en_low_q.bank0[6]) && !wr_enh0 && !wr_enl0
                                        |=> vectored_request_o)
    else $error("enabled request not forwarded");
  a_polled_latches: assert property (ce_i && !gate && !gate_set && pulses_i.portc_pin_request[0]
                                     |=> bank2_q[0] && !vectored_request_o)
    else $error("polled request not latched or forwarded");
  a_read_one_later: assert property (ce_i && rd && adr == `REQ_BANK1_ADDR |=> reg_rdata_o == $past(bank1_q))
    else $error("bank read data wrong");
  a_read_only_once: assert property (ce_i && !rd |=> reg_rdata_o == `BYTE_ZERO)
    else $error("read data outside its cycle");
  a_disabled_pair: assert property ((en_high_q.bank1[3] == 1'b0 && en_low_q.bank1[3] == 1'b0)
                                    |-> enabled_pending.bank1[3] == 1'b0)
    else $error("disabled pair still enables request");
  a_ack_shuts_gate: assert property (ce_i && ack_i.valid |=> !master_gate_o ##1 1'b1)
    else $error("acknowledge left gate open");
  a_event_set_wins: assert property (ce_i && ack_i.valid && wr_eclr && wdat[`EVT_ACK_BIT]
                                     |=> evt_status_q[`EVT_ACK_BIT])
    else $error("event lost against clear");
  a_intr_level: assert property (intr_o == ((evt_status_q & evt_enable_q) != `BYTE_ZERO))
    else $error("interrupt line mismatch");
  a_bank2_upper_zero: assert property (bank2_q[7:4] == 4'h0)
    else $error("bank two upper bits set");
endmodule

/* File: verification/core_side_model.sv */
// ************************************************************
// Request sources and core acknowledge
// ************************************************************
module core_side_model (
  input  wire logic                         core_clk_i,
  input  wire logic                         reset_n_i,
  input  wire irq_latch_pkg::source_pulse_t fire_i,
  input  wire irq_latch_pkg::core_ack_t     ack_req_i,
  output      irq_latch_pkg::source_pulse_t pulses_o,
  output      irq_latch_pkg::core_ack_t     ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_latch_pkg::*;

  source_pulse_t fire_q;
  logic          ack_q;

  // Edge detect: a held request still reaches the block as one cycle
  always_ff @(posedge core_clk_i)
  begin
    fire_q   <= reset_n_i ? fire_i : '0;
    ack_q    <= reset_n_i & ack_req_i.valid;
    pulses_o <= reset_n_i ? (fire_i & ~fire_q) : '0;
    ack_o    <= '{valid: reset_n_i & ack_req_i.valid & ~ack_q, bank: ack_req_i.bank, bit_sel: ack_req_i.bit_sel};
  end
endmodule

/* File: verification/testbench.sv */
`include "irq_latch_map.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_latch_pkg::*;

  logic          core_clk_i;
  logic          reset_n_i;
  logic          ce_i;
  reg_req_t      req;
  gate_ctrl_t    gc;
  source_pulse_t fire;
  source_pulse_t pulses;
  core_ack_t     ack_req;
  core_ack_t     ack;
  byte_t         rdata;
  byte_t         d;
  req_vec_t      bits;
  req_vec_t      en_hi;
  req_vec_t      en_lo;
  logic          gate;
  logic          vreq;
  logic          intr;
  int            bad_count;
  int            comparisons;
  int            cycles;

  interrupt_request_latch dut (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .pulses_i(pulses), .gate_ctrl_i(gc), .ack_i(ack),
    .master_gate_o(gate), .vectored_request_o(vreq), .request_bits_o(bits),
    .enable_high_o(en_hi), .enable_low_o(en_lo), .intr_o(intr)
  );

  core_side_model partner (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .fire_i(fire),
    .ack_req_i(ack_req), .pulses_o(pulses), .ack_o(ack)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Whole-byte store only; software never splits read and write-back
  task automatic wr(input addr_t a, input byte_t v);
    @(posedge core_clk_i) req <= '{1'b1, 1'b0, a, v};
    @(posedge core_clk_i) req <= '0;
    #1;
  endtask

  task automatic rd(input addr_t a, output byte_t v);
    @(posedge core_clk_i) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge core_clk_i) req <= '0;
    #1 v = rdata;
  endtask

  task automatic drive(input source_pulse_t v, input core_ack_t a);
    @(posedge core_clk_i);
    fire    <= v;
    ack_req <= a;
    @(posedge core_clk_i);
    fire    <= '0;
    ack_req <= '0;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic pulse_gate(input gate_ctrl_t g);
    @(posedge core_clk_i) gc <= g;
    @(posedge core_clk_i) gc <= '0;
    #1;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    rd(`REQ_BANK0_ADDR, d);
    check(24'(d), 24'h0);
    rd(`REQ_BANK1_ADDR, d);
    check(24'(d), 24'h0);
    rd(`REQ_BANK2_ADDR, d);
    check(24'(d), 24'h0);
    check(24'({gate, vreq, intr}), 24'h0);
  endtask

  task automatic t_latch;
    drive('1, '0);
    check(bits, 24'h0fff79);
    rd(`REQ_BANK1_ADDR, d);
    check(24'(d), 24'hff);
    wr(`REQ_BANK2_ADDR, 8'hff);
    rd(`REQ_BANK2_ADDR, d);
    check(24'(d), 24'h0f);
    wr(`REQ_BANK0_ADDR, 8'h00);
    wr(`REQ_BANK1_ADDR, 8'h00);
    wr(`REQ_BANK2_ADDR, 8'h00);
    check(bits, 24'h0);
  endtask

  task automatic t_vector;
    wr(`EN_HIGH0_ADDR, 8'hff);
    check(en_hi, 24'h000079);
    wr(`EN_HIGH0_ADDR, 8'h40);
    wr(`REQ_BANK0_ADDR, 8'h40);
    pulse_gate('{1'b1, 1'b0, 1'b0, 1'b0});
    check(24'({gate, vreq}), 24'h3);
    drive('0, '{1'b1, 2'h0, 3'h6});
    check(24'({bits.bank0, gate, vreq}), 24'h0);
    pulse_gate('{1'b0, 1'b1, 1'b0, 1'b0});
    check(24'(gate), 24'h1);
    wr(`GATE_CTRL_ADDR, 8'h00);
    check(24'(gate), 24'h0);
    wr(`GATE_CTRL_ADDR, 8'h01);
    check(24'(gate), 24'h1);
    pulse_gate('{1'b0, 1'b0, 1'b0, 1'b1});
    check(24'(gate), 24'h0);
  endtask

  task automatic t_poll_collide;
    source_pulse_t t0;
    t0 = '0;
    t0.timer_zero_request = 1'b1;
    wr(`EN_LOW0_ADDR, 8'h20);
    drive(t0, '0);
    rd(`REQ_BANK0_ADDR, d);
    check(24'({d, vreq}), 24'h40);
    // Fresh pulse must survive an acknowledge in the same cycle
    drive(t0, '{1'b1, 2'h0, 3'h5});
    check(24'(bits.bank0), 24'h20);
  endtask

  task automatic t_levels;
    source_pulse_t t1;
    t1 = '0;
    t1.timer_one_request = 1'b1;
    // Earlier scenarios leave an enabled timer zero request pending
    wr(`REQ_BANK0_ADDR, 8'h00);
    wr(`REQ_BANK2_ADDR, 8'h01);
    wr(`GATE_CTRL_ADDR, 8'h01);
    for (int code = 0; code < 4; code++)
    begin
      wr(`EN_HIGH2_ADDR, {7'h0, code[1]});
      wr(`EN_LOW2_ADDR, {7'h0, code[0]});
      check(24'(vreq), 24'(code != 0));
    end
    check(en_lo, 24'h010020);
    drive(t1, '0);
    check(24'({bits.bank0, vreq}), 24'h081);
  endtask

  task automatic t_events;
    check(24'(intr), 24'h0);
    wr(`EVT_ENABLE_ADDR, 8'h02);
    check(24'(intr), 24'h1);
    rd(`EVT_STATUS_ADDR, d);
    check(24'(d & 8'h02), 24'h02);
    wr(`EVT_CLEAR_ADDR, 8'h02);
    check(24'(intr), 24'h0);
    // Acknowledge of a bit that is not pending
    drive('0, '{1'b1, 2'h2, 3'h7});
    rd(`EVT_STATUS_ADDR, d);
    check(24'(d), 24'h07);
    check(24'(intr), 24'h1);
    rd(`EVT_CLEAR_ADDR, d);
    check(24'(d), 24'h0);
    rd(12'h100, d);
    check(24'(d), 24'h0);
  endtask

  task automatic t_midreset;
    wr(`REQ_BANK1_ADDR, 8'hff);
    wr(`GATE_CTRL_ADDR, 8'h01);
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    // Frozen block ignores the clearing write
    wr(`REQ_BANK1_ADDR, 8'h00);
    check(24'({bits.bank1, gate}), 24'h1ff);
    @(posedge core_clk_i);
    ce_i      <= 1'b1;
    reset_n_i <= 1'b0;
    @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    #1;
    check(bits, 24'h0);
    check(24'({gate, vreq, intr}), 24'h0);
  endtask

  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Whole run needs about a hundred cycles
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      end_sim();
    end
  end

  initial
  begin
    reset_n_i = 1'b0;
    ce_i      = 1'b1;
    req       = '0;
    gc        = '0;
    fire      = '0;
    ack_req   = '0;
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    #1;
    t_reset();
    t_latch();
    t_vector();
    t_poll_collide();
    t_levels();
    t_events();
    t_midreset();
    end_sim();
  end
endmodule
